/* File: pec_map.svh */
// Constants of the checked-transfer serial target
`ifndef PEC_MAP_SVH
`define PEC_MAP_SVH
`define DEV_ADDR 7'h50
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
`define RD_MIN 8'h01
`define RD_MAX 8'h80
`define WR_MIN 8'h01
`define WR_MAX 8'h04
`define ACK_SLOT 4'h8
`define LAST_BIT 4'h7
`endif

/* File: pec_pkg.sv */
// Types of the checked-transfer serial target
package pec_pkg;
  typedef enum logic [8:0] {
    S_DEV = 9'h001,
    S_MADR = 9'h002,
    S_CNT = 9'h004,
    S_WDAT = 9'h008,
    S_WCRC = 9'h010,
    S_ADDON = 9'h020,
    S_RDAT = 9'h040,
    S_RCRC = 9'h080,
    S_IGN = 9'h100
  } link_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] cnt;
    logic [3:0][7:0] data;
  } wr_cmd_t;
endpackage

/* File: i2c_pec_target.sv */
// Serial target with CRC-8 checked reads and writes, bridged to a memory port
//
// Overview of operation
// - Return successive bytes while host acknowledges
// - Read count must be 1 to 128
// - Send computed CRC byte after last data
// - Read CRC covers pointer, count, data MSB-first
// - CRC polynomial is x8 + x2 + x + 1
// - Acknowledge every checked write data byte
// - At most four data bytes per write
// - ACK add-on byte only on CRC match
// - Write CRC covers pointer, count, data MSB-first
`timescale 1ns/1ps
`include "pec_map.svh"

module i2c_pec_target (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output pec_pkg::mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  output logic crc_fail
);

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  // Link domain, clocked by the bus clock
  pec_pkg::link_state_t state;
  logic start_tgl;
  logic start_seen;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] crc;
  logic [7:0] rx_crc;
  logic [7:0] cnt;
  logic [7:0] sent;
  logic [7:0] ptr;
  logic [7:0] txbyte;
  logic [2:0] widx;
  logic armed;
  logic first;
  logic drv_ack;
  logic fetch_tgl;
  logic [7:0] fetch_addr;
  logic commit_tgl;
  logic fail_tgl;
  pec_pkg::wr_cmd_t wcmd;
  logic r_s1;
  logic r_s2;
  // Core domain
  logic f_s1, f_s2, f_s3;
  logic c_s1, c_s2, c_s3;
  logic x_s1, x_s2, x_s3;
  logic rd_req;
  logic rd_pend;
  logic rdy_tgl;
  logic [7:0] rd_word;
  logic wr_busy;
  logic [2:0] cidx;

  logic [7:0] rx_byte;
  logic new_start;
  logic tx_on;
  logic rd_ready;
  logic [7:0] next_tx;
  assign rx_byte = {shreg[6:0], sda_i};
  assign new_start = start_tgl != start_seen;
  assign tx_on = (state == pec_pkg::S_RDAT || state == pec_pkg::S_RCRC) && !first;
  assign rd_ready = r_s2 == fetch_tgl;
  // A late fetch returns all ones; the CRC is taken over that byte, so it still matches at the host
  assign next_tx = rd_ready ? rd_word : 8'hFF;

  // START seen as SDA falling while SCL is high
  always_ff @(negedge sda_i or negedge nrst) begin
    if (!nrst) begin
      start_tgl <= 1'b0;
    end else if (scl_i) begin
      start_tgl <= ~start_tgl;
    end
  end

  // Ready handshake back from the core domain
  always_ff @(posedge scl_i or negedge nrst) begin
    if (!nrst) begin
      r_s1 <= 1'b0;
      r_s2 <= 1'b0;
    end else begin
      r_s1 <= rdy_tgl;
      r_s2 <= r_s1;
    end
  end

  always_ff @(posedge scl_i or negedge nrst) begin
    if (!nrst) begin
      state <= pec_pkg::S_IGN;
      start_seen <= 1'b0;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      crc <= `CRC_INIT;
      rx_crc <= 8'h00;
      cnt <= 8'h00;
      sent <= 8'h00;
      ptr <= 8'h00;
      txbyte <= 8'h00;
      widx <= 3'h0;
      armed <= 1'b0;
      first <= 1'b0;
      drv_ack <= 1'b0;
      fetch_tgl <= 1'b0;
      fetch_addr <= 8'h00;
      commit_tgl <= 1'b0;
      fail_tgl <= 1'b0;
      wcmd <= '0;
    end else begin
      start_seen <= start_tgl;
      if (new_start) begin
        bitcnt <= 4'h1;
        shreg <= {7'h00, sda_i};
        state <= pec_pkg::S_DEV;
        drv_ack <= 1'b0;
        // A repeated START right after the count keeps the running CRC
        armed <= state == pec_pkg::S_WDAT && widx == 3'h0;
        if (!(state == pec_pkg::S_WDAT && widx == 3'h0)) begin
          crc <= `CRC_INIT;
        end
      end else if (bitcnt == `ACK_SLOT) begin
        bitcnt <= 4'h0;
        drv_ack <= 1'b0;
        if (state == pec_pkg::S_RDAT) begin
          if (first || !sda_i) begin
            first <= 1'b0;
            if (sent == cnt) begin
              txbyte <= crc;
              state <= pec_pkg::S_RCRC;
            end else begin
              txbyte <= next_tx;
              crc <= crc8(crc, next_tx);
              sent <= sent + 8'h01;
              ptr <= ptr + 8'h01;
              fetch_addr <= ptr + 8'h01;
              fetch_tgl <= ~fetch_tgl;
            end
          end else begin
            state <= pec_pkg::S_IGN;
          end
        end else if (state == pec_pkg::S_RCRC) begin
          state <= pec_pkg::S_IGN;
        end
      end else begin
        bitcnt <= bitcnt + 4'h1;
        shreg <= rx_byte;
        if (bitcnt == `LAST_BIT) begin
          drv_ack <= 1'b0;
          case (state)
            pec_pkg::S_DEV: begin
              if (rx_byte[7:1] != `DEV_ADDR) begin
                state <= pec_pkg::S_IGN;
              end else if (!rx_byte[0]) begin
                state <= pec_pkg::S_MADR;
                drv_ack <= 1'b1;
              end else if (armed && cnt >= `RD_MIN && cnt <= `RD_MAX) begin
                state <= pec_pkg::S_RDAT;
                first <= 1'b1;
                sent <= 8'h00;
                drv_ack <= 1'b1;
              end else begin
                state <= pec_pkg::S_IGN;
              end
            end
            pec_pkg::S_MADR: begin
              ptr <= rx_byte;
              crc <= crc8(crc, rx_byte);
              fetch_addr <= rx_byte;
              fetch_tgl <= ~fetch_tgl;
              state <= pec_pkg::S_CNT;
              drv_ack <= 1'b1;
            end
            pec_pkg::S_CNT: begin
              cnt <= rx_byte;
              crc <= crc8(crc, rx_byte);
              widx <= 3'h0;
              state <= pec_pkg::S_WDAT;
              drv_ack <= 1'b1;
            end
            pec_pkg::S_WDAT: begin
              if (cnt >= `WR_MIN && cnt <= `WR_MAX && {5'h00, widx} < cnt) begin
                wcmd.data[widx[1:0]] <= rx_byte;
                crc <= crc8(crc, rx_byte);
                widx <= widx + 3'h1;
                drv_ack <= 1'b1;
                if ({5'h00, widx} + 8'h01 == cnt) begin
                  state <= pec_pkg::S_WCRC;
                end
              end else begin
                state <= pec_pkg::S_IGN;
              end
            end
            pec_pkg::S_WCRC: begin
              rx_crc <= rx_byte;
              state <= pec_pkg::S_ADDON;
              drv_ack <= 1'b1;
            end
            pec_pkg::S_RDAT, pec_pkg::S_RCRC: begin
              // Still shifting out; the acknowledge slot decides what follows
              state <= state;
            end
            pec_pkg::S_ADDON: begin
              drv_ack <= rx_crc == crc;
              state <= pec_pkg::S_IGN;
              if (rx_crc == crc) begin
                wcmd.addr <= ptr;
                wcmd.cnt <= cnt[2:0];
                commit_tgl <= ~commit_tgl;
              end else begin
                fail_tgl <= ~fail_tgl;
              end
            end
            default: begin
              state <= pec_pkg::S_IGN;
            end
          endcase
        end
      end
    end
  end

  // SDA changes only while SCL is low
  always_ff @(negedge scl_i or negedge nrst) begin
    if (!nrst) begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      if (bitcnt == `ACK_SLOT) begin
        sda_oe <= drv_ack;
      end else begin
        sda_oe <= tx_on && !txbyte[3'h7 - bitcnt[2:0]];
      end
    end
  end

  // Crossing into the core domain; data words are held stable by the link side
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      f_s1 <= 1'b0;
      f_s2 <= 1'b0;
      f_s3 <= 1'b0;
      c_s1 <= 1'b0;
      c_s2 <= 1'b0;
      c_s3 <= 1'b0;
      x_s1 <= 1'b0;
      x_s2 <= 1'b0;
      x_s3 <= 1'b0;
    end else begin
      f_s1 <= fetch_tgl;
      f_s2 <= f_s1;
      f_s3 <= f_s2;
      c_s1 <= commit_tgl;
      c_s2 <= c_s1;
      c_s3 <= c_s2;
      x_s1 <= fail_tgl;
      x_s2 <= x_s1;
      x_s3 <= x_s2;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      crc_fail <= 1'b0;
    end else begin
      crc_fail <= x_s2 != x_s3;
    end
  end

  // Memory port; writes take priority, a fetch waits behind them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_req <= '0;
      rd_req <= 1'b0;
      rd_pend <= 1'b0;
      rdy_tgl <= 1'b0;
      rd_word <= 8'h00;
      wr_busy <= 1'b0;
      cidx <= 3'h0;
    end else begin
      mem_req.rd <= 1'b0;
      mem_req.wr <= 1'b0;
      rd_pend <= 1'b0;
      if (f_s2 != f_s3) begin
        rd_req <= 1'b1;
      end
      if (rd_pend) begin
        rd_word <= mem_rdata;
        rdy_tgl <= f_s3;
      end
      if (c_s2 != c_s3) begin
        wr_busy <= 1'b1;
        cidx <= 3'h1;
        mem_req.wr <= 1'b1;
        mem_req.addr <= wcmd.addr;
        mem_req.wdata <= wcmd.data[0];
      end else if (wr_busy && cidx < wcmd.cnt) begin
        cidx <= cidx + 3'h1;
        mem_req.wr <= 1'b1;
        mem_req.addr <= wcmd.addr + {5'h00, cidx};
        mem_req.wdata <= wcmd.data[cidx[1:0]];
      end else if (wr_busy) begin
        wr_busy <= 1'b0;
      end else if (rd_req && !rd_pend) begin
        rd_req <= 1'b0;
        rd_pend <= 1'b1;
        mem_req.rd <= 1'b1;
        mem_req.addr <= fetch_addr;
      end
    end
  end

  property p_rd_count;
    @(posedge scl_i) disable iff (!nrst)
    !new_start && state == pec_pkg::S_DEV && bitcnt == `LAST_BIT && rx_byte[0] &&
      (cnt == 8'h00 || cnt > `RD_MAX) |=> state == pec_pkg::S_IGN && !drv_ack;
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("bad read count accepted");

  property p_crc_after_data;
    @(posedge scl_i) disable iff (!nrst)
    !new_start && state == pec_pkg::S_RDAT && bitcnt == `ACK_SLOT && !first && !sda_i &&
      sent == cnt |=> state == pec_pkg::S_RCRC && txbyte == $past(crc);
  endproperty
  a_crc_after_data: assert property (p_crc_after_data) else $error("CRC byte not sent");

  property p_ptr_step;
    @(posedge scl_i) disable iff (!nrst)
    !new_start && state == pec_pkg::S_RDAT && bitcnt == `ACK_SLOT && !sda_i && sent != cnt
      |=> ptr == $past(ptr) + 8'h01 && crc == crc8($past(crc), txbyte);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer or CRC not stepped");

  property p_wr_ack;
    @(posedge scl_i) disable iff (!nrst)
    !new_start && state == pec_pkg::S_WDAT && bitcnt == `LAST_BIT && cnt >= `WR_MIN &&
      cnt <= `WR_MAX |=> drv_ack ##1 bitcnt == 4'h0;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write data not acked");

  property p_wr_limit;
    @(posedge scl_i) disable iff (!nrst)
    !new_start && state == pec_pkg::S_WDAT && bitcnt == `LAST_BIT && cnt > `WR_MAX
      |=> !drv_ack && state == pec_pkg::S_IGN;
  endproperty
  a_wr_limit: assert property (p_wr_limit) else $error("long write accepted");

  property p_addon;
    @(posedge scl_i) disable iff (!nrst)
    !new_start && state == pec_pkg::S_ADDON && bitcnt == `LAST_BIT
      |=> drv_ack == ($past(rx_crc) == $past(crc)) && commit_tgl != $past(commit_tgl) == drv_ack;
  endproperty
  a_addon: assert property (p_addon) else $error("add-on answer wrong");

  property p_crc_clear;
    @(posedge scl_i) disable iff (!nrst)
    new_start && !(state == pec_pkg::S_WDAT && widx == 3'h0) |=> crc == `CRC_INIT;
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("CRC not cleared at START");

  property p_crc_ptr;
    @(posedge scl_i) disable iff (!nrst)
    !new_start && state == pec_pkg::S_MADR && bitcnt == `LAST_BIT
      |=> crc == crc8($past(crc), ptr) && state == pec_pkg::S_CNT;
  endproperty
  a_crc_ptr: assert property (p_crc_ptr) else $error("pointer not in CRC");

  property p_commit;
    @(posedge core_clk) disable iff (!nrst)
    c_s2 != c_s3 |=> mem_req.wr && mem_req.addr == wcmd.addr && mem_req.wdata == wcmd.data[0];
  endproperty
  a_commit: assert property (p_commit) else $error("commit write missing");

  c_read_crc: cover property (@(posedge scl_i) disable iff (!nrst) state == pec_pkg::S_RCRC);
  c_addon_ok: cover property (@(posedge scl_i) disable iff (!nrst)
    state == pec_pkg::S_ADDON && bitcnt == `LAST_BIT && rx_crc == crc);
  c_addon_bad: cover property (@(posedge core_clk) disable iff (!nrst) crc_fail);
  c_mem_write: cover property (@(posedge core_clk) disable iff (!nrst) mem_req.wr);

endmodule // i2c_pec_target

/* File: i2c_host_model.sv */
// Bus master model that drives checked transfers
`timescale 1ns/1ps

module i2c_host_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start_cond();
    sda_low = 1'b0;
    #40 scl = 1'b1;
    #40 sda_low = 1'b1;
    #40 scl = 1'b0;
    #40;
  endtask

  task automatic stop_cond();
    sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
    #40;
  endtask

  // Data changes only while the clock is low
  task automatic put_bit(input logic b, output logic seen);
    sda_low = ~b;
    #40 scl = 1'b1;
    #80 seen = sda;
    scl = 1'b0;
    #40;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  // NACK on the CRC byte ends a read
  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
    put_bit(~ack, s);
  endtask
endmodule // i2c_host_model

/* File: i2c_pec_target_test.sv */
// Self-checking bench for the checked-transfer serial target
`timescale 1ns/1ps

module i2c_pec_target_test;
  logic core_clk = 1'b0;
  logic nrst;
  logic scl, sda_low, sda, sda_o, sda_oe, crc_fail;
  pec_pkg::mem_req_t mem_req;
  logic [7:0] mem_rdata;
  logic [7:0] mem [256];
  logic [7:0] model_mem [256];
  int miscompares = 0;
  int checks = 0;
  int fails = 0;
  int writes = 0;
  int cycles = 0;

  always #50 core_clk = ~core_clk;
  // Open drain with pull-up; the device pulls low only with a zero on its data output
  assign sda = ~(sda_low | (sda_oe & ~sda_o));
  // Memory answers while the read strobe stands; the design takes it at the next edge
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : 8'h00;

  i2c_host_model u_i2c_host_model (.scl(scl), .sda_low(sda_low), .sda(sda));

  i2c_pec_target u_i2c_pec_target (
    .core_clk(core_clk),
    .nrst(nrst),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .mem_req(mem_req),
    .mem_rdata(mem_rdata),
    .crc_fail(crc_fail)
  );

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (crc_fail === 1'b1) fails <= fails + 1;
    if (mem_req.wr === 1'b1) begin
      mem[mem_req.addr] <= mem_req.wdata;
      writes <= writes + 1;
    end
    if (cycles == 10000) begin
      miscompares = miscompares + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction

  task automatic write_burst(input logic [7:0] ptr, input int cnt, input logic bad);
    logic [7:0] b [$];
    logic [7:0] c, d;
    logic ack, nack;
    int w0, f0;
    b = {8'hA0, ptr, 8'(cnt)};
    c = crc_step(crc_step(8'h00, ptr), 8'(cnt));
    for (int i = 0; i < cnt; i++) begin
      d = 8'hC3 ^ 8'(ptr + i * 5);
      b.push_back(d);
      c = crc_step(c, d);
      if (!bad && cnt <= 4) model_mem[8'(ptr + i)] = d;
    end
    b.push_back(c ^ {7'h00, bad});
    b.push_back(8'h00);
    w0 = writes;
    f0 = fails;
    nack = 1'b0;
    u_i2c_host_model.start_cond();
    for (int j = 0; j < b.size() && !nack; j++) begin
      u_i2c_host_model.put_byte(b[j], ack);
      if (cnt <= 4) chk("write ack", {7'h00, (j != b.size() - 1) || !bad}, {7'h00, ack});
      nack = !ack;
    end
    u_i2c_host_model.stop_cond();
    repeat (20) @(posedge core_clk);
    chk("write refused", {7'h00, bad || cnt > 4}, {7'h00, nack});
    chk("bytes committed", 8'((bad || cnt > 4) ? 0 : cnt), 8'(writes - w0));
    chk("crc fail pulses", {7'h00, bad}, 8'(fails - f0));
    for (int i = 0; i < 4; i++) chk("memory", model_mem[8'(ptr + i)], mem[8'(ptr + i)]);
  endtask

  task automatic read_burst(input logic [7:0] ptr, input int cnt);
    logic [7:0] c, d;
    logic ack;
    c = crc_step(crc_step(8'h00, ptr), 8'(cnt));
    u_i2c_host_model.start_cond();
    u_i2c_host_model.put_byte(8'hA0, ack);
    u_i2c_host_model.put_byte(ptr, ack);
    u_i2c_host_model.put_byte(8'(cnt), ack);
    chk("count ack", 8'h01, {7'h00, ack});
    // The count is only judged once the repeated START shows a read
    u_i2c_host_model.start_cond();
    u_i2c_host_model.put_byte(8'hA1, ack);
    chk("read address ack", {7'h00, cnt >= 1 && cnt <= 128}, {7'h00, ack});
    if (ack) begin
      for (int i = 0; i < cnt; i++) begin
        u_i2c_host_model.get_byte(1'b1, d);
        chk("read data", model_mem[8'(ptr + i)], d);
        c = crc_step(c, d);
      end
      u_i2c_host_model.get_byte(1'b0, d);
      chk("read crc", c, d);
    end
    u_i2c_host_model.stop_cond();
    repeat (5) @(posedge core_clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    // Falls at time zero so the asynchronous reset branches really run
    nrst <= 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
      model_mem[i] = mem[i];
    end
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
    write_burst(8'h10, 4, 1'b0);
    write_burst(8'h20, 1, 1'b0);
    write_burst(8'h10, 3, 1'b1);
    write_burst(8'h30, 5, 1'b0);
    read_burst(8'h0E, 6);
    read_burst(8'h80, 128);
    read_burst(8'h20, 1);
    read_burst(8'h40, 0);
    read_burst(8'h40, 129);
    tally_and_finish();
  end
endmodule // i2c_pec_target_test
